// [design/atr_pkg.sv]
// Constants for the auxiliary limit and identity register bank
package atr_pkg;
  // Bus and field geometry
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 32;
  localparam int SAMPLE_W = 16;
  localparam int LIM_W    = 14;
  localparam int LIM_LSB  = 2;
  localparam int CHAN_W   = 3;
  localparam int NUM_HI   = 6;
  localparam int NUM_LO   = 5;
  localparam int STAT_W   = 11;
  localparam int STAT_UV  = 6;
  localparam int BATCH_BYTES  = 8;
  localparam int SERIAL_BYTES = 2;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_AUX2_HIGH = 8'h9c;
  localparam logic [7:0] IDX_AUX3_LOW  = 8'h9e;
  localparam logic [7:0] IDX_AUX3_HIGH = 8'ha0;
  localparam logic [7:0] IDX_AUX4_LOW  = 8'ha2;
  localparam logic [7:0] IDX_AUX4_HIGH = 8'ha4;
  localparam logic [7:0] IDX_AUX5_LOW  = 8'ha6;
  localparam logic [7:0] IDX_AUX5_HIGH = 8'ha8;
  localparam logic [7:0] IDX_AUX6_LOW  = 8'haa;
  localparam logic [7:0] IDX_AUX6_HIGH = 8'hac;
  localparam logic [7:0] IDX_AUX7_LOW  = 8'hae;
  localparam logic [7:0] IDX_AUX7_HIGH = 8'hb0;
  localparam logic [7:0] IDX_STATUS    = 8'hb2;
  localparam logic [7:0] IDX_MASK      = 8'hb4;
  localparam logic [7:0] IDX_BATCH     = 8'hbe;
  localparam logic [7:0] IDX_SERIAL    = 8'hc6;

  localparam logic [7:0] IDX_HIGH [NUM_HI] = '{IDX_AUX2_HIGH,
    IDX_AUX3_HIGH, IDX_AUX4_HIGH, IDX_AUX5_HIGH, IDX_AUX6_HIGH,
    IDX_AUX7_HIGH};
  localparam logic [7:0] IDX_LOW [NUM_LO] = '{IDX_AUX3_LOW,
    IDX_AUX4_LOW, IDX_AUX5_LOW, IDX_AUX6_LOW, IDX_AUX7_LOW};

  // First channel numbers of the limit sets
  localparam logic [2:0] FIRST_HI_CH = 3'h2;
  localparam logic [2:0] FIRST_LO_CH = 3'h3;

  // Reset values
  localparam logic [LIM_W-1:0]  HI_RESET   = 14'h3fff;
  localparam logic [LIM_W-1:0]  LO_RESET   = 14'h0000;
  localparam logic [1:0]        RESERVED_LOW_BITS_BITS  = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RESET = 11'h000;
endpackage : atr_pkg

// [design/atr_limit_cmp.sv]
// One auxiliary channel: limit compare and fault flags
`timescale 1ns/10ps
module atr_limit_cmp #(
  parameter bit HAS_LOW = 1'b1
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        hit_in,
  input  wire logic [atr_pkg::SAMPLE_W-1:0] sample_in,
  input  wire logic [atr_pkg::LIM_W-1:0]    high_field_in,
  input  wire logic [atr_pkg::LIM_W-1:0]    low_field_in,
  output logic                             ov_event_out,
  output logic                             uv_event_out,
  output logic                             ov_flag_out,
  output logic                             uv_flag_out
);
  logic [atr_pkg::SAMPLE_W-1:0] high_thr;
  logic [atr_pkg::SAMPLE_W-1:0] low_thr;

  // Field is the top of a 16-bit threshold with zero low bits
  assign high_thr = {high_field_in, atr_pkg::RESERVED_LOW_BITS_BITS};
  assign low_thr  = {low_field_in, atr_pkg::RESERVED_LOW_BITS_BITS};

  assign ov_event_out = hit_in && (sample_in > high_thr);
  assign uv_event_out = HAS_LOW && hit_in
                        && (sample_in < low_thr);

  // Flags follow the latest sample of this channel
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ov_flag_out <= 1'b0;
      uv_flag_out <= 1'b0;
    end else if (hit_in) begin
      ov_flag_out <= ov_event_out;
      uv_flag_out <= uv_event_out;
    end
  end
endmodule : atr_limit_cmp

// [design/atr_sticky_status.sv]
// Sticky event status with read clear, mask and interrupt
`timescale 1ns/10ps
module atr_sticky_status #(
  parameter int W = 11
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] set_in,
  input  wire logic         read_clear_in,
  input  wire logic [W-1:0] mask_in,
  output logic      [W-1:0] status_out,
  output logic              irq_out
);
  logic [W-1:0] status_next;

  // A new event in the clearing cycle survives the clear
  assign status_next = (read_clear_in ? '0 : status_out) | set_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_out <= '0;
    end else begin
      status_out <= status_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_next & mask_in);
    end
  end
endmodule : atr_sticky_status

// [design/atr_aux_limit_regs.sv]
// Auxiliary limit registers, identity registers and fault flags
// What this block does
// - Hold high limit for aux two to seven
// - Hold low limit for aux three to seven
// - Limits span zero to five volts linearly
// - Low two bits read zero, written zero
// - Expose 64-bit batch identity over eight bytes
// - Expose 16-bit unit serial after batch identity
// - Threshold is field with two zero bits
`timescale 1ns/10ps
module atr_aux_limit_regs #(
  // Arbitrary identity values, replaced per part at integration
  parameter logic [63:0] BATCH_ID  = 64'h0011_2233_4455_6677,
  parameter logic [15:0] SERIAL_ID = 16'h0a5a
) (
  // Clock and reset
  input  wire logic                          REF_CLK_IN,
  input  wire logic                          RST_N_IN,
  // Avalon-MM slave
  input  wire logic [atr_pkg::ADDR_W-1:0]    AVS_ADDRESS_IN,
  input  wire logic                          AVS_READ_IN,
  input  wire logic                          AVS_WRITE_IN,
  input  wire logic [atr_pkg::DATA_W-1:0]    AVS_WRITEDATA_IN,
  input  wire logic [3:0]                    AVS_BYTEENABLE_IN,
  output logic      [atr_pkg::DATA_W-1:0]    AVS_READDATA_OUT,
  output logic                               AVS_WAITREQUEST_OUT,
  // Auxiliary samples
  input  wire logic [atr_pkg::SAMPLE_W-1:0]  AUX_SAMPLE_IN,
  input  wire logic [atr_pkg::CHAN_W-1:0]    AUX_CHANNEL_IN,
  input  wire logic                          AUX_SAMPLE_VALID_IN,
  // Fault flags and interrupt
  output logic      [atr_pkg::NUM_HI-1:0]    AUX_OV_FLAG_OUT,
  output logic      [atr_pkg::NUM_LO-1:0]    AUX_UV_FLAG_OUT,
  output logic                               IRQ_OUT
);
  localparam int LW = atr_pkg::LIM_W;
  localparam int SW = atr_pkg::STAT_W;

  logic [LW-1:0]  high_lim_reg [atr_pkg::NUM_HI];
  logic [LW-1:0]  low_lim_reg  [atr_pkg::NUM_LO];
  logic [SW-1:0]  mask_reg;
  logic [SW-1:0]  status;
  logic [7:0]     index;
  logic           request;
  logic           accept;
  logic           write_ok;
  logic           read_cap;
  logic [atr_pkg::DATA_W-1:0] rdata_next;
  logic           stat_read;
  logic [atr_pkg::NUM_HI-1:0] ov_event;
  logic [atr_pkg::NUM_HI-1:0] uv_event;
  logic [atr_pkg::NUM_HI-1:0] ov_flag;
  logic [atr_pkg::NUM_HI-1:0] uv_flag;
  logic [SW-1:0]  stat_set;
  logic           irq;
  logic [7:0]     batch_bytes [atr_pkg::BATCH_BYTES];
  logic [7:0]     serial_bytes [atr_pkg::SERIAL_BYTES];

  // Bus handshake: wait drops for one cycle, one edge after request
  assign index    = AVS_ADDRESS_IN[atr_pkg::ADDR_W-1:2];
  assign request  = AVS_READ_IN || AVS_WRITE_IN;
  assign accept   = request && !AVS_WAITREQUEST_OUT;
  assign write_ok = accept && AVS_WRITE_IN;
  // Read data is captured on the first edge of a read, while wait is high
  assign read_cap = AVS_READ_IN && AVS_WAITREQUEST_OUT;

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      AVS_WAITREQUEST_OUT <= !(request && AVS_WAITREQUEST_OUT);
    end
  end

  // Merge enabled byte lanes into a 14-bit field; low lanes bits 1:0 drop
  function automatic logic [LW-1:0] merge_field(
    input logic [LW-1:0] cur,
    input logic [atr_pkg::DATA_W-1:0] wd,
    input logic [3:0] be
  );
    logic [15:0] full;
    full = {cur, atr_pkg::RESERVED_LOW_BITS_BITS};
    if (be[0]) begin
      full[7:0] = wd[7:0];
    end
    if (be[1]) begin
      full[15:8] = wd[15:8];
    end
    merge_field = full[15:atr_pkg::LIM_LSB];
  endfunction : merge_field

  // High limit registers
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < atr_pkg::NUM_HI; i++) begin
        high_lim_reg[i] <= atr_pkg::HI_RESET;
      end
    end else if (write_ok) begin
      for (int i = 0; i < atr_pkg::NUM_HI; i++) begin
        if (index == atr_pkg::IDX_HIGH[i]) begin
          high_lim_reg[i] <= merge_field(high_lim_reg[i],
            AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        end
      end
    end
  end

  // Low limit registers
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < atr_pkg::NUM_LO; i++) begin
        low_lim_reg[i] <= atr_pkg::LO_RESET;
      end
    end else if (write_ok) begin
      for (int i = 0; i < atr_pkg::NUM_LO; i++) begin
        if (index == atr_pkg::IDX_LOW[i]) begin
          low_lim_reg[i] <= merge_field(low_lim_reg[i],
            AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        end
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mask_reg <= atr_pkg::MASK_RESET;
    end else if (write_ok && index == atr_pkg::IDX_MASK) begin
      mask_reg <= AVS_WRITEDATA_IN[SW-1:0];
    end
  end

  // Identity bytes, most significant byte at the lowest address
  always_comb begin
    for (int b = 0; b < atr_pkg::BATCH_BYTES; b++) begin
      batch_bytes[b] = BATCH_ID[63-8*b -: 8];
    end
    for (int b = 0; b < atr_pkg::SERIAL_BYTES; b++) begin
      serial_bytes[b] = SERIAL_ID[15-8*b -: 8];
    end
  end

  // Read decode; unmapped indices read as zero
  always_comb begin
    rdata_next = '0;
    if (index == atr_pkg::IDX_STATUS) begin
      rdata_next[SW-1:0] = status;
    end else if (index == atr_pkg::IDX_MASK) begin
      rdata_next[SW-1:0] = mask_reg;
    end else if (index >= atr_pkg::IDX_BATCH
                 && index < atr_pkg::IDX_SERIAL) begin
      rdata_next[7:0] =
        batch_bytes[3'(index - atr_pkg::IDX_BATCH)];
    end else if (index >= atr_pkg::IDX_SERIAL
                 && index < atr_pkg::IDX_SERIAL
                            + 8'(atr_pkg::SERIAL_BYTES)) begin
      rdata_next[7:0] =
        serial_bytes[1'(index - atr_pkg::IDX_SERIAL)];
    end else begin
      for (int i = 0; i < atr_pkg::NUM_HI; i++) begin
        if (index == atr_pkg::IDX_HIGH[i]) begin
          rdata_next[15:0] = {high_lim_reg[i], atr_pkg::RESERVED_LOW_BITS_BITS};
        end
      end
      for (int i = 0; i < atr_pkg::NUM_LO; i++) begin
        if (index == atr_pkg::IDX_LOW[i]) begin
          rdata_next[15:0] = {low_lim_reg[i], atr_pkg::RESERVED_LOW_BITS_BITS};
        end
      end
    end
  end

  // Data is captured while wait is high so it stands at the accept edge
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      AVS_READDATA_OUT <= '0;
    end else if (read_cap) begin
      AVS_READDATA_OUT <= rdata_next;
    end
  end

  // Per-channel comparators; aux2 has no low limit
  for (genvar c = 0; c < atr_pkg::NUM_HI; c++) begin : g_chan
    logic hit;
    assign hit = AUX_SAMPLE_VALID_IN
      && AUX_CHANNEL_IN == atr_pkg::FIRST_HI_CH + 3'(c);
    atr_limit_cmp #(
      .HAS_LOW (c != 0)
    ) u_cmp (
      .clk_in        (REF_CLK_IN),
      .rst_n_in      (RST_N_IN),
      .hit_in        (hit),
      .sample_in     (AUX_SAMPLE_IN),
      .high_field_in (high_lim_reg[c]),
      .low_field_in  ((c == 0) ? atr_pkg::LO_RESET
                                : low_lim_reg[(c == 0) ? 0 : c - 1]),
      .ov_event_out  (ov_event[c]),
      .uv_event_out  (uv_event[c]),
      .ov_flag_out   (ov_flag[c]),
      .uv_flag_out   (uv_flag[c])
    );
  end

  // Status layout: bits 5:0 over, aux2..7; bits 10:6 under, aux3..7
  assign stat_set  = {uv_event[atr_pkg::NUM_HI-1:1], ov_event};
  // Clear on the capture edge: an event landing between capture and
  // accept would otherwise be wiped without ever being reported
  assign stat_read = read_cap && index == atr_pkg::IDX_STATUS;

  atr_sticky_status #(
    .W (SW)
  ) u_status (
    .clk_in        (REF_CLK_IN),
    .rst_n_in      (RST_N_IN),
    .set_in        (stat_set),
    .read_clear_in (stat_read),
    .mask_in       (mask_reg),
    .status_out    (status),
    .irq_out       (irq)
  );

  assign IRQ_OUT         = irq;
  assign AUX_OV_FLAG_OUT = ov_flag;
  assign AUX_UV_FLAG_OUT = uv_flag[atr_pkg::NUM_HI-1:1];
endmodule : atr_aux_limit_regs

// [test/atr_aux_limit_regs_asserts.sv]
// Port checker for the auxiliary limit register bank
`timescale 1ns/10ps
module atr_aux_limit_regs_chk (
  // Clock and reset
  input wire logic        REF_CLK_IN,
  input wire logic        RST_N_IN,
  // Register bus
  input wire logic [9:0]  AVS_ADDRESS_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic        AVS_WAITREQUEST_OUT,
  // Samples and flags
  input wire logic [15:0] AUX_SAMPLE_IN,
  input wire logic [2:0]  AUX_CHANNEL_IN,
  input wire logic        AUX_SAMPLE_VALID_IN,
  input wire logic [5:0]  AUX_OV_FLAG_OUT,
  input wire logic [4:0]  AUX_UV_FLAG_OUT,
  input wire logic        IRQ_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  wait_low_a:
    assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
      |=> !AVS_WAITREQUEST_OUT) else $error("request not answered");
  wait_one_a:
    assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
      else $error("wait low too long");
  rdata_hold_a:
    assert property (!(AVS_READ_IN && AVS_WAITREQUEST_OUT)
      |=> $stable(AVS_READDATA_OUT)) else $error("read data moved");
  reserved_low_bits_zero_a:
    assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT
      && AVS_ADDRESS_IN[9:2] >= 8'h9c && AVS_ADDRESS_IN[9:2] <= 8'hb1
      |-> AVS_READDATA_OUT[1:0] == 2'h0) else $error("low bits set");
  ov_max_a:
    assert property (AUX_SAMPLE_VALID_IN && AUX_CHANNEL_IN >= 3'h2
      && AUX_SAMPLE_IN == 16'hffff
      |=> AUX_OV_FLAG_OUT[$past(AUX_CHANNEL_IN) - 3'h2])
      else $error("full scale not over limit");
  ov_zero_a:
    assert property (AUX_SAMPLE_VALID_IN && AUX_CHANNEL_IN >= 3'h2
      && AUX_SAMPLE_IN == 16'h0000
      |=> !AUX_OV_FLAG_OUT[$past(AUX_CHANNEL_IN) - 3'h2])
      else $error("zero sample over limit");
  uv_max_a:
    assert property (AUX_SAMPLE_VALID_IN && AUX_CHANNEL_IN >= 3'h3
      && AUX_SAMPLE_IN == 16'hffff
      |=> !AUX_UV_FLAG_OUT[$past(AUX_CHANNEL_IN) - 3'h3])
      else $error("full scale under limit");
  flag_hold_a:
    assert property (!AUX_SAMPLE_VALID_IN
      |=> $stable({AUX_UV_FLAG_OUT, AUX_OV_FLAG_OUT}))
      else $error("flags moved without sample");
  irq_rise_a:
    assert property ($rose(IRQ_OUT) |-> $past(AUX_SAMPLE_VALID_IN)
      || $past(AVS_WRITE_IN) || $past(AVS_WRITE_IN, 2))
      else $error("interrupt without cause");
endmodule : atr_aux_limit_regs_chk

bind atr_aux_limit_regs atr_aux_limit_regs_chk atr_aux_limit_regs_chk_i (
  .REF_CLK_IN, .RST_N_IN, .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN,
  .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .AUX_SAMPLE_IN, .AUX_CHANNEL_IN,
  .AUX_SAMPLE_VALID_IN, .AUX_OV_FLAG_OUT, .AUX_UV_FLAG_OUT, .IRQ_OUT);

// [test/atr_aux_limit_regs_bench.sv]
// Self-checking bench for the auxiliary limit register bank
`timescale 1ns/10ps
module atr_aux_limit_regs_bench;
  typedef struct packed {
    logic [7:0]  idx;
    logic [31:0] wd;
    logic [31:0] exp;
  } atr_row_t;
  // Arbitrary identity values
  localparam logic [63:0] BID = 64'h8877_6655_4433_2211;
  localparam logic [15:0] SID = 16'hc3e1;
  logic        clk, rst_n, rd_en, wr_en, vld, wt, irq;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata, rd;
  logic [15:0] smp;
  logic [2:0]  ch;
  logic [3:0]  be;
  logic [5:0]  ov;
  logic [4:0]  uv;
  int          bad_count = 0, checks_done = 0, cycles = 0;
  // Write value, then expected read back; low two bits never stick
  atr_row_t rows [14] = '{
    '{8'h9c, 32'h0000ffff, 32'h0000fffc}, '{8'h9e, 32'hffff1235, 32'h1234},
    '{8'ha0, 32'h2222, 32'h2220}, '{8'ha2, 32'h3333, 32'h3330},
    '{8'ha4, 32'h4447, 32'h4444}, '{8'ha6, 32'h5555, 32'h5554},
    '{8'ha8, 32'h6666, 32'h6664}, '{8'haa, 32'h7777, 32'h7774},
    '{8'hac, 32'h8888, 32'h8888}, '{8'hae, 32'h9999, 32'h9998},
    '{8'hb0, 32'haaab, 32'haaa8}, '{8'h9a, 32'hffff, 32'h0},
    '{8'hc6, 32'hff, {24'h0, SID[15:8]}}, '{8'hc7, 32'h0, {24'h0, SID[7:0]}}};

  atr_aux_limit_regs #(.BATCH_ID(BID), .SERIAL_ID(SID)) atr_aux_limit_regs_i (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd_en), .AVS_WRITE_IN(wr_en), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(wt), .AUX_SAMPLE_IN(smp), .AUX_CHANNEL_IN(ch),
    .AUX_SAMPLE_VALID_IN(vld), .AUX_OV_FLAG_OUT(ov), .AUX_UV_FLAG_OUT(uv),
    .IRQ_OUT(irq));

  task automatic end_of_test;
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the request until wait is seen low; the global timeout ends a hang
  task automatic bus(input logic we, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk);
    rd_en <= !we;
    wr_en <= we;
    addr  <= {idx, 2'b00};
    wdata <= wd;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask : bus

  task automatic samp(input logic [2:0] c, input logic [15:0] s,
                      input logic [10:0] exp);
    @(posedge clk);
    vld <= 1'b1;
    ch  <= c;
    smp <= s;
    @(posedge clk);
    vld <= 1'b0;
    #1 check({21'h0, uv, ov}, {21'h0, exp});
  endtask : samp

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      $display("MISMATCH %0t run took too long", $time);
      end_of_test;
    end
  end

  initial begin
    rst_n = 1'b0; rd_en = 1'b0; wr_en = 1'b0; vld = 1'b0;
    addr = 10'h0; wdata = 32'h0; smp = 16'h0; ch = 3'h0; be = 4'hf;
    repeat (2) @(posedge clk);
    check({19'h0, wt, irq, uv, ov}, 32'h1000);
    rst_n <= 1'b1;
    bus(1'b0, 8'h9c, 32'h0, rd); check(rd, 32'hfffc);
    bus(1'b0, 8'h9e, 32'h0, rd); check(rd, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd, rd);
      bus(1'b0, rows[i].idx, 32'h0, rd);
      check(rd, rows[i].exp);
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 8'(8'hbe + i), 32'h0, rd);
      check(rd, {24'h0, BID[63 - 8 * i -: 8]});
    end
    // Only the enabled byte lanes may change a limit
    be <= 4'h2;
    bus(1'b1, 8'h9c, 32'h5500, rd);
    be <= 4'h1;
    bus(1'b1, 8'h9c, 32'h00ab, rd);
    be <= 4'hf;
    bus(1'b0, 8'h9c, 32'h0, rd);
    check(rd, 32'h55a8);
    // Stray low bits written must not shift the compare point
    bus(1'b1, 8'ha0, 32'h1003, rd);
    bus(1'b1, 8'h9e, 32'h0803, rd);
    samp(3'h3, 16'h1000, 11'h000);
    samp(3'h3, 16'h1002, 11'h002);
    samp(3'h3, 16'h07ff, 11'h040);
    samp(3'h3, 16'h0801, 11'h000);
    samp(3'h7, 16'hffff, 11'h020);
    samp(3'h2, 16'h0000, 11'h020);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, 8'hb4, 32'h40, rd);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    bus(1'b0, 8'hb4, 32'h0, rd); check(rd, 32'h40);
    bus(1'b0, 8'hb2, 32'h0, rd); check(rd, 32'h62);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, 8'hb2, 32'h0, rd); check(rd, 32'h0);
    // A reset in mid-run restores limits, drops flags and raises wait
    rst_n <= 1'b0;
    @(posedge clk);
    check({19'h0, wt, irq, uv, ov}, 32'h1000);
    rst_n <= 1'b1;
    bus(1'b0, 8'h9c, 32'h0, rd);
    check(rd, 32'hfffc);
    bus(1'b0, 8'h9e, 32'h0, rd);
    check(rd, 32'h0);
    end_of_test;
  end
endmodule : atr_aux_limit_regs_bench
